/* File: logic/ccc_pkg.sv */
// Shared constants, register map and carrier types for the charge core
package ccc_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TIME_TICK_NS = 878900000;
  localparam int TIME_TICK_CYC = TIME_TICK_NS / CLK_PERIOD_NS;
  localparam int SLOW_DIV = 256;
  localparam int SD_TICKS_25C = 4096;
  localparam int OFFS_LSB_NS = 9760000;
  localparam int OFFS_LSB_CYC = OFFS_LSB_NS / CLK_PERIOD_NS;

  // Flash operation limits, longest times rounded down
  localparam int BLOCK_PROG_US = 1520;
  localparam int BLOCK_ERASE_US = 1520;
  localparam int BYTE_PROG_US = 90;
  localparam int BLOCK_PROG_CYC = BLOCK_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int BYTE_PROG_CYC = BYTE_PROG_US * 1000 / CLK_PERIOD_NS;

  // Die temperature points in kelvin
  localparam logic [8:0] TEMP_25C_K = 9'h12a;
  localparam logic [8:0] TEMP_HI_K = 9'h14d;
  localparam logic [8:0] TEMP_LO_K = 9'h111;
  localparam logic [8:0] TEMP_STEP_K = 9'h00a;

  // Register addresses
  localparam logic [6:0] ADDR_MODE = 7'h60;
  localparam logic [6:0] ADDR_CLR = 7'h61;
  localparam logic [6:0] ADDR_FCMD = 7'h62;
  localparam logic [6:0] ADDR_SCR_L = 7'h63;
  localparam logic [6:0] ADDR_SCR_H = 7'h64;
  localparam logic [6:0] ADDR_DTC_L = 7'h65;
  localparam logic [6:0] ADDR_DTC_H = 7'h66;
  localparam logic [6:0] ADDR_CTC_L = 7'h67;
  localparam logic [6:0] ADDR_CTC_H = 7'h68;
  localparam logic [6:0] ADDR_CCR_L = 7'h6b;
  localparam logic [6:0] ADDR_CCR_H = 7'h6c;
  localparam logic [6:0] ADDR_DCR_L = 7'h6d;
  localparam logic [6:0] ADDR_DCR_H = 7'h6e;
  localparam logic [6:0] ADDR_OFF_L = 7'h75;
  localparam logic [6:0] ADDR_OFF_M = 7'h76;
  localparam logic [6:0] ADDR_CAL_H = 7'h77;

  // Clear register bit positions
  localparam int CLR_DCR = 0;
  localparam int CLR_CCR = 1;
  localparam int CLR_SCR = 2;
  localparam int CLR_DTC = 3;
  localparam int CLR_CTC = 4;

  // Mode register bit positions
  localparam int MODE_SLOW_C = 0;
  localparam int MODE_SLOW_D = 1;
  localparam int MODE_REGDIS = 2;

  // Calibration/offset high register bit positions
  localparam int CAL_COMPENSATION_ENABLE_BIT = 7;
  localparam int CAL_REQ = 6;
  localparam int CAL_OK_N = 5;
  localparam int CAL_CHARGE_OFFSET_SELECT_BIT = 4;

  // Command codes
  localparam logic [7:0] CMD_SLEEP = 8'h01;
  localparam logic [7:0] CMD_HWRST = 8'h02;
  localparam logic [7:0] CMD_PROG = 8'h03;
  localparam logic [7:0] CMD_LOAD = 8'h04;
  localparam logic [7:0] CMD_ERASE = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h06;

  // Flash sequencer states
  typedef enum logic [2:0] {
    FL_IDLE, FL_PROG, FL_LOAD, FL_ERASE, FL_BYTE
  } ccc_flash_t;

  // Register request and answer carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ccc_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ccc_rsp_t;

endpackage

/* File: logic/ccc_tick_gen.sv */
// Free-running period divider producing one-cycle ticks
`timescale 1ns/100ps
module ccc_tick_gen #(
  parameter int PERIOD = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Control and tick
  input wire logic restart_i,
  output logic tick_o
);

  localparam int W = $clog2(PERIOD + 1);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_ff;

  // Count up and wrap; restart realigns the phase
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else if (restart_i || cnt_ff == LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  // Tick on the last count of each period
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !restart_i && cnt_ff == LAST;
    end
  end

endmodule

/* File: logic/ccc_core.sv */
// Coulomb counting core: charge, time, self-discharge and offset counters
`timescale 1ns/100ps
module ccc_core #(
  parameter int TICK_CYC = ccc_pkg::TIME_TICK_CYC,
  parameter int OFFS_CYC = ccc_pkg::OFFS_LSB_CYC,
  parameter int PROG_CYC = ccc_pkg::BLOCK_PROG_CYC,
  parameter int ERASE_CYC = ccc_pkg::BLOCK_ERASE_CYC,
  parameter int BYTE_CYC = ccc_pkg::BYTE_PROG_CYC,
  parameter int SD_TICKS = ccc_pkg::SD_TICKS_25C
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Converter pulses and sign
  input wire logic chg_pulse_i,
  input wire logic dsg_pulse_i,
  input wire logic sense_pos_i,
  input wire logic sense_neg_i,
  // Die temperature in kelvin, calibration and wake events
  input wire logic [8:0] temp_k_i,
  input wire logic cal_done_i,
  input wire logic wake_i,
  // Decoded register access from the single-wire port
  input wire ccc_pkg::ccc_req_t req_i,
  output ccc_pkg::ccc_rsp_t rsp_o,
  // Device controls
  output logic reg_disable_o,
  output logic sleep_o,
  output ccc_pkg::ccc_flash_t flash_op_o,
  output logic flash_busy_o
);

  logic tick;
  logic offs_tick;
  logic [15:0] ccr_ff;
  logic [15:0] dcr_ff;
  logic [15:0] scr_ff;
  logic [15:0] tc_ff [2];
  logic [7:0] pre_ff [2];
  logic [1:0] slow_ff;
  logic [4:0] clr_ff;
  logic [19:0] offs_ff;
  logic [19:0] offs_cnt_ff;
  logic [15:0] sd_cnt_ff;
  logic compensation_enable_bit_ff;
  logic charge_offset_select_bit_ff;
  logic calok_n_ff;
  logic regdis_ff;
  logic hwrst_ff;
  logic comp_hit;
  logic [15:0] sd_period;
  logic [19:0] fl_cnt_ff;
  logic [1:0] tc_clr;
  logic [1:0] tc_run;
  logic [1:0] tc_inc;
  logic wr_cmd;

  // Decoded write strobes
  function automatic logic wr_at(input ccc_pkg::ccc_req_t r,
                                 input logic [6:0] a);
    return r.wr && r.addr == a;
  endfunction

  assign wr_cmd = wr_at(req_i, ccc_pkg::ADDR_FCMD);

  // Base time tick and offset LSB tick
  ccc_tick_gen #(.PERIOD(TICK_CYC)) u_time_tick (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .restart_i(hwrst_ff),
    .tick_o(tick)
  );

  ccc_tick_gen #(.PERIOD(OFFS_CYC)) u_offs_tick (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .restart_i(!compensation_enable_bit_ff),
    .tick_o(offs_tick)
  );

  // clear request latch
  // Host set wins over the self-clear so a fresh write is never lost
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clr_ff <= '0;
    end else if (wr_at(req_i, ccc_pkg::ADDR_CLR)) begin
      clr_ff <= req_i.wdata[4:0];
    end else begin
      clr_ff <= '0;
    end
  end

  // Offset and calibration control bits
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      offs_ff <= '0;
      compensation_enable_bit_ff <= 1'b0;
      charge_offset_select_bit_ff <= 1'b0;
      calok_n_ff <= 1'b1;
    end else if (hwrst_ff) begin
      compensation_enable_bit_ff <= 1'b0;
      calok_n_ff <= 1'b1;
    end else begin
      if (wr_at(req_i, ccc_pkg::ADDR_OFF_L)) begin
        offs_ff[7:0] <= req_i.wdata;
      end
      if (wr_at(req_i, ccc_pkg::ADDR_OFF_M)) begin
        offs_ff[15:8] <= req_i.wdata;
      end
      if (wr_at(req_i, ccc_pkg::ADDR_CAL_H)) begin
        offs_ff[19:16] <= req_i.wdata[3:0];
        compensation_enable_bit_ff <= req_i.wdata[ccc_pkg::CAL_COMPENSATION_ENABLE_BIT];
        charge_offset_select_bit_ff <= req_i.wdata[ccc_pkg::CAL_CHARGE_OFFSET_SELECT_BIT];
      end
      // A new request re-arms calibration; completion wins
      if (cal_done_i) begin
        calok_n_ff <= 1'b0;
      end else if (wr_at(req_i, ccc_pkg::ADDR_CAL_H) &&
                   req_i.wdata[ccc_pkg::CAL_REQ]) begin
        calok_n_ff <= 1'b1;
      end
    end
  end

  // regulator amplifier disable
  // Sleep does not touch this bit, so the regulator stays up asleep
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      regdis_ff <= 1'b0;
    end else if (hwrst_ff) begin
      regdis_ff <= 1'b0;
    end else if (wr_at(req_i, ccc_pkg::ADDR_MODE)) begin
      regdis_ff <= req_i.wdata[ccc_pkg::MODE_REGDIS];
    end
  end

  assign reg_disable_o = regdis_ff;

  // period is the offset value in 9.76 ms steps
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      offs_cnt_ff <= '0;
    end else if (!compensation_enable_bit_ff || calok_n_ff || offs_ff == '0) begin
      offs_cnt_ff <= '0;
    end else if (offs_tick) begin
      offs_cnt_ff <= comp_hit ? '0 : offs_cnt_ff + 20'h00001;
    end
  end

  // one count per elapsed offset period
  assign comp_hit = offs_tick && compensation_enable_bit_ff && !calok_n_ff &&
                    offs_ff != '0 && offs_cnt_ff == offs_ff - 20'h00001;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ccr_ff <= '0;
    end else if (hwrst_ff || clr_ff[ccc_pkg::CLR_CCR]) begin
      ccr_ff <= '0;
    end else begin
      ccr_ff <= ccr_ff + 16'(chg_pulse_i && !sleep_o) +
                16'(comp_hit && charge_offset_select_bit_ff);
    end
  end

  // both charge counters are 16 bits
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dcr_ff <= '0;
    end else if (hwrst_ff || clr_ff[ccc_pkg::CLR_DCR]) begin
      dcr_ff <= '0;
    end else begin
      dcr_ff <= dcr_ff + 16'(dsg_pulse_i && !sleep_o) +
                16'(comp_hit && !charge_offset_select_bit_ff);
    end
  end

  // clearing either timer resets both rates
  assign tc_clr[0] = hwrst_ff || clr_ff[ccc_pkg::CLR_CTC];
  assign tc_clr[1] = hwrst_ff || clr_ff[ccc_pkg::CLR_DTC];

  // Charge timer (0) and discharge timer (1)
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tc
      // each timer runs only with its own sign
      // a zero sense holds both timers
      assign tc_run[g] = !sleep_o && (g == 0 ? sense_pos_i : sense_neg_i);
      // slow rate takes 256 base ticks per count
      assign tc_inc[g] = tick && tc_run[g] &&
                         (!slow_ff[g] || pre_ff[g] == 8'hff);

      // Slow-rate prescaler
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pre_ff[g] <= '0;
        end else if (tc_clr[0] || tc_clr[1]) begin
          pre_ff[g] <= '0;
        end else if (tick && tc_run[g] && slow_ff[g]) begin
          pre_ff[g] <= pre_ff[g] + 8'h01;
        end
      end

      // timer steps once per base tick, or once per 256 base ticks at slow rate
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          tc_ff[g] <= '0;
        end else if (tc_clr[g]) begin
          tc_ff[g] <= '0;
        end else if (tc_inc[g]) begin
          tc_ff[g] <= tc_ff[g] + 16'h0001;
        end
      end

      // wrap sets the slow flag
      // A wrap of the other timer in a clear cycle still sets: set wins
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          slow_ff[g] <= 1'b0;
        end else if (tc_inc[g] && tc_ff[g] == 16'hffff && !tc_clr[g]) begin
          slow_ff[g] <= 1'b1;
        end else if (tc_clr[0] || tc_clr[1]) begin
          slow_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // doubling above 25C, capped at 60C
  // halving below 25C, floored at 0C
  always_comb begin
    logic [8:0] t;
    t = temp_k_i;
    sd_period = 16'(SD_TICKS);
    if (t > ccc_pkg::TEMP_HI_K) begin
      t = ccc_pkg::TEMP_HI_K;
    end
    if (t < ccc_pkg::TEMP_LO_K) begin
      t = ccc_pkg::TEMP_LO_K;
    end
    if (t >= ccc_pkg::TEMP_25C_K) begin
      sd_period = sd_period >> ((t - ccc_pkg::TEMP_25C_K) /
                                ccc_pkg::TEMP_STEP_K);
    end else begin
      sd_period = sd_period << ((ccc_pkg::TEMP_25C_K - t +
                                 ccc_pkg::TEMP_STEP_K - 9'h001) /
                                ccc_pkg::TEMP_STEP_K);
    end
  end

  // self-discharge counts every period of base ticks
  // Runs in sleep as well, as does offset compensation into the charge counters
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sd_cnt_ff <= '0;
      scr_ff <= '0;
    end else if (hwrst_ff || clr_ff[ccc_pkg::CLR_SCR]) begin
      sd_cnt_ff <= '0;
      scr_ff <= '0;
    end else if (tick) begin
      if (sd_cnt_ff + 16'h0001 >= sd_period) begin
        sd_cnt_ff <= '0;
        scr_ff <= scr_ff + 16'h0001;
      end else begin
        sd_cnt_ff <= sd_cnt_ff + 16'h0001;
      end
    end
  end

  // command decode for sleep and hardware reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hwrst_ff <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      hwrst_ff <= wr_cmd && req_i.wdata == ccc_pkg::CMD_HWRST;
      if (wr_cmd && req_i.wdata == ccc_pkg::CMD_SLEEP) begin
        sleep_o <= 1'b1;
      end else if (wake_i || req_i.wr || req_i.rd) begin
        sleep_o <= 1'b0;
      end
    end
  end

  // program and erase end on their block time; byte and load both end on the byte time
  // Flash commands arriving while busy are ignored; sleep and hardware reset commands still act
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flash_op_o <= ccc_pkg::FL_IDLE;
      flash_busy_o <= 1'b0;
      fl_cnt_ff <= '0;
    end else if (flash_op_o == ccc_pkg::FL_IDLE) begin
      if (wr_cmd) begin
        unique case (req_i.wdata)
          ccc_pkg::CMD_PROG: begin
            flash_op_o <= ccc_pkg::FL_PROG;
            flash_busy_o <= 1'b1;
            fl_cnt_ff <= 20'(PROG_CYC - 1);
          end
          ccc_pkg::CMD_ERASE: begin
            flash_op_o <= ccc_pkg::FL_ERASE;
            flash_busy_o <= 1'b1;
            fl_cnt_ff <= 20'(ERASE_CYC - 1);
          end
          ccc_pkg::CMD_BYTE: begin
            flash_op_o <= ccc_pkg::FL_BYTE;
            flash_busy_o <= 1'b1;
            fl_cnt_ff <= 20'(BYTE_CYC - 1);
          end
          ccc_pkg::CMD_LOAD: begin
            flash_op_o <= ccc_pkg::FL_LOAD;
            flash_busy_o <= 1'b1;
            fl_cnt_ff <= 20'(BYTE_CYC - 1);
          end
          default: begin
            flash_op_o <= ccc_pkg::FL_IDLE;
          end
        endcase
      end
    end else if (fl_cnt_ff == '0) begin
      // Busy is its own flop so the output comes straight from a register
      flash_op_o <= ccc_pkg::FL_IDLE;
      flash_busy_o <= 1'b0;
    end else begin
      fl_cnt_ff <= fl_cnt_ff - 20'h00001;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.rd;
      unique case (req_i.addr)
        ccc_pkg::ADDR_MODE:
          rsp_o.data <= {5'h00, regdis_ff, slow_ff[1], slow_ff[0]};
        ccc_pkg::ADDR_CLR: rsp_o.data <= {3'h0, clr_ff};
        ccc_pkg::ADDR_FCMD: rsp_o.data <= {7'h00, flash_busy_o};
        ccc_pkg::ADDR_SCR_L: rsp_o.data <= scr_ff[7:0];
        ccc_pkg::ADDR_SCR_H: rsp_o.data <= scr_ff[15:8];
        ccc_pkg::ADDR_DTC_L: rsp_o.data <= tc_ff[1][7:0];
        ccc_pkg::ADDR_DTC_H: rsp_o.data <= tc_ff[1][15:8];
        ccc_pkg::ADDR_CTC_L: rsp_o.data <= tc_ff[0][7:0];
        ccc_pkg::ADDR_CTC_H: rsp_o.data <= tc_ff[0][15:8];
        ccc_pkg::ADDR_CCR_L: rsp_o.data <= ccr_ff[7:0];
        ccc_pkg::ADDR_CCR_H: rsp_o.data <= ccr_ff[15:8];
        ccc_pkg::ADDR_DCR_L: rsp_o.data <= dcr_ff[7:0];
        ccc_pkg::ADDR_DCR_H: rsp_o.data <= dcr_ff[15:8];
        ccc_pkg::ADDR_OFF_L: rsp_o.data <= offs_ff[7:0];
        ccc_pkg::ADDR_OFF_M: rsp_o.data <= offs_ff[15:8];
        ccc_pkg::ADDR_CAL_H:
          rsp_o.data <= {compensation_enable_bit_ff, 1'b0, calok_n_ff, charge_offset_select_bit_ff,
                         offs_ff[19:16]};
        default: rsp_o.data <= 8'h00;
      endcase
    end
  end

  // Checks on counting, regulator disable and flash behaviour
  property p_dcr_step;
    @(posedge mclk_i) disable iff (!nrst_i)
    dsg_pulse_i && !sleep_o && !comp_hit && !hwrst_ff && !clr_ff[0]
    |=> dcr_ff == $past(dcr_ff) + 16'h0001;
  endproperty
  a_dcr_step: assert property (p_dcr_step)
    else $error("discharge counter missed a pulse");

  property p_ccr_only;
    @(posedge mclk_i) disable iff (!nrst_i)
    chg_pulse_i && !dsg_pulse_i && !comp_hit && !hwrst_ff && !clr_ff[0]
    |=> dcr_ff == $past(dcr_ff);
  endproperty
  a_ccr_only: assert property (p_ccr_only)
    else $error("charge pulse disturbed discharge counter");

  property p_tc_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
    !sense_neg_i && !tc_clr[1] |=> tc_ff[1] == $past(tc_ff[1]);
  endproperty
  a_tc_hold: assert property (p_tc_hold)
    else $error("discharge timer moved outside discharge");

  property p_wrap_slow;
    @(posedge mclk_i) disable iff (!nrst_i)
    tc_inc[0] && tc_ff[0] == 16'hffff && !tc_clr[0] && !tc_clr[1]
    |=> tc_ff[0] == 16'h0000 && slow_ff[0];
  endproperty
  a_wrap_slow: assert property (p_wrap_slow)
    else $error("charge timer wrap did not enter slow rate");

  property p_clr_self;
    @(posedge mclk_i) disable iff (!nrst_i)
    wr_at(req_i, ccc_pkg::ADDR_CLR) && req_i.wdata[1]
    |=> clr_ff[1] ##1 ccr_ff <= 16'h0002 &&
    clr_ff[1] == $past(req_i.wr && req_i.addr == ccc_pkg::ADDR_CLR &&
                       req_i.wdata[1]);
  endproperty
  a_clr_self: assert property (p_clr_self)
    else $error("clear bit did not zero counter and return");

  property p_clr_slow;
    @(posedge mclk_i) disable iff (!nrst_i)
    clr_ff[ccc_pkg::CLR_DTC] && !(tc_inc[0] && tc_ff[0] == 16'hffff)
    |=> slow_ff == 2'b00;
  endproperty
  a_clr_slow: assert property (p_clr_slow)
    else $error("timer clear left a slow flag set");

  property p_regdis;
    @(posedge mclk_i) disable iff (!nrst_i)
    wr_at(req_i, ccc_pkg::ADDR_MODE) && !hwrst_ff
    |=> reg_disable_o == $past(req_i.wdata[ccc_pkg::MODE_REGDIS]);
  endproperty
  a_regdis: assert property (p_regdis)
    else $error("regulator disable did not follow the mode bit");

  property p_flash_len;
    @(posedge mclk_i) disable iff (!nrst_i)
    flash_busy_o |-> fl_cnt_ff < 20'(flash_op_o == ccc_pkg::FL_ERASE ?
      ERASE_CYC : flash_op_o == ccc_pkg::FL_PROG ? PROG_CYC : BYTE_CYC);
  endproperty
  a_flash_len: assert property (p_flash_len)
    else $error("flash operation exceeds its time limit");

  property p_zero_sense;
    @(posedge mclk_i) disable iff (!nrst_i)
    !sense_pos_i && !sense_neg_i && !tc_clr[0] |=>
    tc_ff[0] == $past(tc_ff[0]);
  endproperty
  a_zero_sense: assert property (p_zero_sense)
    else $error("charge timer moved with zero sense");

  property p_no_comp;
    @(posedge mclk_i) disable iff (!nrst_i)
    calok_n_ff && !chg_pulse_i && !hwrst_ff && !clr_ff[ccc_pkg::CLR_CCR]
    |=> ccr_ff == $past(ccr_ff);
  endproperty
  a_no_comp: assert property (p_no_comp)
    else $error("compensation before successful calibration");

  // Main scenarios
  c_comp: cover property (@(posedge mclk_i) disable iff (!nrst_i) comp_hit);
  c_slow: cover property (@(posedge mclk_i) disable iff (!nrst_i)
                          slow_ff[1]);
  c_flash: cover property (@(posedge mclk_i) disable iff (!nrst_i)
                           flash_busy_o ##1 !flash_busy_o);

endmodule

/* File: tb/ccc_host_model.sv */
// Host-side model issuing byte accesses on the decoded register port
`timescale 1ns/100ps
module ccc_host_model (
  // Clock
  input wire logic mclk_i,
  // Register port
  output ccc_pkg::ccc_req_t req_o,
  input wire ccc_pkg::ccc_rsp_t rsp_i
);
  // Idle request until the bench asks for an access
  initial req_o = '0;

  // single strobe access
  // Strobe held over one rising edge; answer taken one cycle later.
  // Released fields show inverted values so stale data never passes.
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [7:0] wd, output logic [7:0] rd_o,
                     output logic ok);
    @(negedge mclk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: wd};
    @(negedge mclk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
    rd_o = rsp_i.data;
    ok = w | rsp_i.valid;
  endtask
endmodule

/* File: tb/tb_ccc_core.sv */
// Self-checking bench for the charge-accounting core
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb_ccc_core;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic chg_pulse_i = 1'b0;
  logic dsg_pulse_i = 1'b0;
  logic sense_pos_i = 1'b0;
  logic sense_neg_i = 1'b0;
  logic [8:0] temp_k_i = ccc_pkg::TEMP_25C_K;
  logic cal_done_i = 1'b0;
  logic wake_i = 1'b0;
  ccc_pkg::ccc_req_t req;
  ccc_pkg::ccc_rsp_t rsp;
  ccc_pkg::ccc_flash_t fop;
  logic reg_dis, slp, busy;
  int n_errors = 0;
  int checked = 0;

  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;

  // Short counts keep the run small; byte and load keep their real time
  ccc_core #(.TICK_CYC(4), .OFFS_CYC(3), .PROG_CYC(20), .ERASE_CYC(20),
    .SD_TICKS(16)) i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .chg_pulse_i(chg_pulse_i), .dsg_pulse_i(dsg_pulse_i),
    .sense_pos_i(sense_pos_i), .sense_neg_i(sense_neg_i),
    .temp_k_i(temp_k_i), .cal_done_i(cal_done_i), .wake_i(wake_i),
    .req_i(req), .rsp_o(rsp), .reg_disable_o(reg_dis), .sleep_o(slp),
    .flash_op_o(fop), .flash_busy_o(busy));

  // Host on the register port
  ccc_host_model i_host (.mclk_i(mclk_i), .req_o(req), .rsp_i(rsp));

  // Register access helpers
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic ok;
    i_host.acc(1'b1, a, d, x, ok);
  endtask
  task automatic rd8(input logic [6:0] a, output logic [7:0] d);
    logic ok;
    i_host.acc(1'b0, a, 8'h00, d, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rd16(input logic [6:0] a, output logic [15:0] v);
    logic [7:0] l, h;
    rd8(a, l);
    rd8(a + 7'h01, h);
    v = {h, l};
  endtask
  function automatic bit in_rng(logic [15:0] v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction

  // Sense sign held for a number of cycles, then back to zero
  task automatic run(input logic p, input logic n, input int c);
    sense_pos_i = p;
    sense_neg_i = n;
    repeat (c) @(negedge mclk_i);
    sense_pos_i = 1'b0;
    sense_neg_i = 1'b0;
  endtask
  task automatic pulse(input logic chg, input int n);
    repeat (n) begin
      @(negedge mclk_i);
      chg_pulse_i = chg;
      dsg_pulse_i = !chg;
      @(negedge mclk_i);
      chg_pulse_i = 1'b0;
      dsg_pulse_i = 1'b0;
    end
  endtask

  task automatic t_reset;
    logic [15:0] v;
    logic [7:0] b;
    rd16(ccc_pkg::ADDR_DCR_L, v);
    `CHK(v, 16'h0000)
    rd16(ccc_pkg::ADDR_CTC_L, v);
    `CHK(v, 16'h0000)
    rd8(7'h74, b);
    `CHK(b, 8'h00)
    $display("test reset done");
  endtask

  task automatic t_count;
    logic [15:0] v;
    logic [7:0] b;
    wr8(ccc_pkg::ADDR_CLR, 8'h03);
    sense_neg_i = 1'b1;
    pulse(1'b0, 3);
    sense_neg_i = 1'b0;
    sense_pos_i = 1'b1;
    pulse(1'b1, 5);
    sense_pos_i = 1'b0;
    wr8(ccc_pkg::ADDR_CCR_L, 8'hff);
    rd16(ccc_pkg::ADDR_DCR_L, v);
    `CHK(v, 16'h0003)
    rd16(ccc_pkg::ADDR_CCR_L, v);
    `CHK(v, 16'h0005)
    wr8(ccc_pkg::ADDR_CLR, 8'h01);
    rd8(ccc_pkg::ADDR_CLR, b);
    `CHK(b, 8'h00)
    rd16(ccc_pkg::ADDR_DCR_L, v);
    `CHK(v, 16'h0000)
    rd16(ccc_pkg::ADDR_CCR_L, v);
    `CHK(v, 16'h0005)
    $display("test count done");
  endtask

  task automatic t_timer;
    logic [15:0] d, c;
    wr8(ccc_pkg::ADDR_CLR, 8'h18);
    run(1'b0, 1'b1, 40);
    rd16(ccc_pkg::ADDR_DTC_L, d);
    rd16(ccc_pkg::ADDR_CTC_L, c);
    `CHK(in_rng(d, 9, 11), 1'b1)
    `CHK(c, 16'h0000)
    run(1'b1, 1'b0, 40);
    rd16(ccc_pkg::ADDR_CTC_L, c);
    `CHK(in_rng(c, 9, 11), 1'b1)
    rd16(ccc_pkg::ADDR_DTC_L, c);
    `CHK(c, d)
    run(1'b0, 1'b0, 40);
    rd16(ccc_pkg::ADDR_DTC_L, c);
    `CHK(c, d)
    $display("test timer done");
  endtask

  task automatic t_misc;
    logic [15:0] v;
    wr8(ccc_pkg::ADDR_MODE, 8'h04);
    `CHK(reg_dis, 1'b1)
    wr8(ccc_pkg::ADDR_MODE, 8'h00);
    `CHK(reg_dis, 1'b0)
    wr8(ccc_pkg::ADDR_FCMD, ccc_pkg::CMD_SLEEP);
    `CHK(slp, 1'b1)
    sense_neg_i = 1'b1;
    pulse(1'b0, 2);
    sense_neg_i = 1'b0;
    wake_i = 1'b1;
    @(negedge mclk_i);
    wake_i = 1'b0;
    @(negedge mclk_i);
    `CHK(slp, 1'b0)
    rd16(ccc_pkg::ADDR_DCR_L, v);
    `CHK(v, 16'h0000)
    $display("test misc done");
  endtask

  task automatic t_flash;
    logic [7:0] cmd[4] = '{8'h03, 8'h05, 8'h06, 8'h04};
    ccc_pkg::ccc_flash_t op[4] = '{ccc_pkg::FL_PROG, ccc_pkg::FL_ERASE,
      ccc_pkg::FL_BYTE, ccc_pkg::FL_LOAD};
    int n[4] = '{20, 20, ccc_pkg::BYTE_PROG_CYC, ccc_pkg::BYTE_PROG_CYC};
    int cnt;
    for (int i = 0; i < 4; i++) begin
      wr8(ccc_pkg::ADDR_FCMD, cmd[i]);
      `CHK(fop, op[i])
      cnt = 0;
      while (busy !== 1'b0 && cnt < n[i] + 8) begin
        @(negedge mclk_i);
        cnt++;
      end
      `CHK(in_rng(cnt, n[i] - 3, n[i]), 1'b1)
    end
    $display("test flash done");
  endtask

  task automatic t_selfdis;
    logic [8:0] tk[3] = '{ccc_pkg::TEMP_25C_K, ccc_pkg::TEMP_HI_K,
      ccc_pkg::TEMP_LO_K};
    int per[3] = '{16, 2, 128};
    logic [15:0] v;
    int e;
    for (int i = 0; i < 3; i++) begin
      temp_k_i = tk[i];
      wr8(ccc_pkg::ADDR_CLR, 8'h04);
      run(1'b0, 1'b0, 640);
      rd16(ccc_pkg::ADDR_SCR_L, v);
      e = 640 / (4 * per[i]);
      `CHK(in_rng(v, e - 1, e + 2), 1'b1)
    end
    temp_k_i = ccc_pkg::TEMP_25C_K;
    $display("test selfdis done");
  endtask

  task automatic t_comp;
    logic [15:0] v;
    logic [7:0] b;
    wr8(ccc_pkg::ADDR_OFF_L, 8'h02);
    wr8(ccc_pkg::ADDR_OFF_M, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr8(ccc_pkg::ADDR_CAL_H, 8'h90);
      wr8(ccc_pkg::ADDR_CLR, 8'h03);
      run(1'b0, 1'b0, 60);
      wr8(ccc_pkg::ADDR_CAL_H, 8'h10);
      rd16(ccc_pkg::ADDR_CCR_L, v);
      `CHK(in_rng(v, k * 9, k * 12), 1'b1)
      rd16(ccc_pkg::ADDR_DCR_L, v);
      `CHK(v, 16'h0000)
      cal_done_i = 1'b1;
      @(negedge mclk_i);
      cal_done_i = 1'b0;
    end
    wr8(ccc_pkg::ADDR_CAL_H, 8'h40);
    rd8(ccc_pkg::ADDR_CAL_H, b);
    `CHK(b, 8'h20)
    wr8(ccc_pkg::ADDR_MODE, 8'h04);
    wr8(ccc_pkg::ADDR_FCMD, ccc_pkg::CMD_HWRST);
    @(negedge mclk_i);
    `CHK(reg_dis, 1'b0)
    $display("test comp done");
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (100000) @(posedge mclk_i);
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (3) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_reset();
    t_count();
    t_timer();
    t_misc();
    t_flash();
    t_selfdis();
    t_comp();
    end_of_test();
  end
endmodule
